// [t1_timer.sv]
// 8-bit timer channel one: counter, two compare constants, flags, output pin
// and interrupt, with an APB register slave.
// assumes EXT_CLK and EXT_RST are asynchronous pins far slower than MCLK.
`timescale 1ns/1ps
module t1_timer #(
  parameter int DIV_A_LOG2 = 3,
  parameter int DIV_B_LOG2 = 6,
  parameter int DIV_C_LOG2 = 10
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [t1_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_CLK,
  input wire logic EXT_RST,
  output logic TMO,
  output logic TMO_OE,
  output logic CMB_REQ,
  output logic IRQ
);
  import t1_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction

  function automatic logic os_apply(input logic [1:0] act, input logic cur);
    case (act)
      OS_LOW: return 1'b0;
      OS_HIGH: return 1'b1;
      OS_TOGGLE: return ~cur;
      default: return cur;
    endcase
  endfunction

  t1_ctrl_t ctrl_reg;
  t1_outsel_t outsel_reg;
  logic [7:0] cnt_reg;
  logic [7:0] cora_reg;
  logic [7:0] corb_reg;
  logic [FLAG_N-1:0] flag_reg;
  logic [FLAG_N-1:0] armed_reg;
  logic [FLAG_N-1:0] irq_sts_reg;
  logic [FLAG_N-1:0] irq_en_reg;
  logic [FLAG_N-1:0] ev;
  logic [FLAG_N-1:0] src_en;
  logic [31:0] rdata_reg;
  logic [31:0] rmux;
  logic tmo_reg;
  logic [DIV_C_LOG2-1:0] div_reg;
  logic [2:0] eclk_sync_reg;
  logic [2:0] erst_sync_reg;
  logic ext_rise, ext_fall, ext_rst_rise;
  logic tick, match_a, match_b, clr_on_match, ext_clr;
  logic setup, access, wr, rd, mapped;
  logic wr_ctrl, wr_flags, wr_cora, wr_corb, wr_cnt, wr_irq_clr, wr_irq_en, rd_flags;

  // bus decode; zero wait states, so every access phase completes at once
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  assign wr = access & PWRITE;
  assign rd = access & ~PWRITE;
  assign wr_ctrl = wr & hit(PADDR, IDX_CTRL);
  assign wr_flags = wr & hit(PADDR, IDX_FLAGS);
  assign wr_cora = wr & hit(PADDR, IDX_CORA);
  assign wr_corb = wr & hit(PADDR, IDX_CORB);
  assign wr_cnt = wr & hit(PADDR, IDX_CNT);
  assign wr_irq_clr = wr & hit(PADDR, IDX_IRQ_CLR);
  assign wr_irq_en = wr & hit(PADDR, IDX_IRQ_EN);
  assign rd_flags = rd & hit(PADDR, IDX_FLAGS);
  assign PREADY = PENABLE;
  assign PSLVERR = access & ~mapped;
  assign PRDATA = rdata_reg;

  always_comb begin
    mapped = 1'b1;
    rmux = 32'h0000_0000;
    if (hit(PADDR, IDX_CTRL)) begin
      rmux[7:0] = ctrl_reg;
    end else if (hit(PADDR, IDX_FLAGS)) begin
      rmux[7:0] = {flag_reg, 1'b1, outsel_reg};
    end else if (hit(PADDR, IDX_CORA)) begin
      rmux[7:0] = cora_reg;
    end else if (hit(PADDR, IDX_CORB)) begin
      rmux[7:0] = corb_reg;
    end else if (hit(PADDR, IDX_CNT)) begin
      rmux[7:0] = cnt_reg;
    end else if (hit(PADDR, IDX_IRQ_STS)) begin
      rmux[FLAG_N-1:0] = irq_sts_reg;
    end else if (hit(PADDR, IDX_IRQ_EN)) begin
      rmux[FLAG_N-1:0] = irq_en_reg;
    end else if (!hit(PADDR, IDX_IRQ_CLR)) begin
      mapped = 1'b0;
    end
  end

  // read data captured in setup so it comes from flops during access
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      rdata_reg <= rmux;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_reg <= CTRL_RST;
      outsel_reg <= OUTSEL_RST;
      cora_reg <= COR_RST;
      corb_reg <= COR_RST;
      irq_en_reg <= FLAG_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= PWDATA[7:0];
      end
      if (wr_flags) begin
        outsel_reg <= PWDATA[3:0];
      end
      if (wr_cora) begin
        cora_reg <= PWDATA[7:0];
      end
      if (wr_corb) begin
        corb_reg <= PWDATA[7:0];
      end
      if (wr_irq_en) begin
        irq_en_reg <= PWDATA[FLAG_N-1:0];
      end
    end
  end

  // pins pass two flops; stage 0 feeds only stage 1, edges use stages 1 and 2
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      eclk_sync_reg <= 3'h0;
      erst_sync_reg <= 3'h0;
    end else begin
      eclk_sync_reg <= {eclk_sync_reg[1:0], EXT_CLK};
      erst_sync_reg <= {erst_sync_reg[1:0], EXT_RST};
    end
  end

  assign ext_rise = eclk_sync_reg[1] & ~eclk_sync_reg[2];
  assign ext_fall = ~eclk_sync_reg[1] & eclk_sync_reg[2];
  assign ext_rst_rise = erst_sync_reg[1] & ~erst_sync_reg[2];

  // free-running prescaler; each internal rate is a one-cycle enable
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_comb begin
    case (ctrl_reg.cks)
      CKS_DIV_A: tick = &div_reg[DIV_A_LOG2-1:0];
      CKS_DIV_B: tick = &div_reg[DIV_B_LOG2-1:0];
      CKS_DIV_C: tick = &div_reg;
      CKS_EXT_RISE: tick = ext_rise;
      CKS_EXT_FALL: tick = ext_fall;
      CKS_EXT_BOTH: tick = ext_rise | ext_fall;
      default: tick = 1'b0;
    endcase
  end

  // a match is seen on the tick that would leave the matching value
  assign match_a = tick & (cnt_reg == cora_reg);
  assign match_b = tick & (cnt_reg == corb_reg);
  assign clr_on_match = (ctrl_reg.cclr == CCLR_CMA && match_a) ||
                        (ctrl_reg.cclr == CCLR_CMB && match_b);
  assign ext_clr = (ctrl_reg.cclr == CCLR_EXT) & ext_rst_rise;
  assign ev[EV_OVF] = tick & (cnt_reg == CNT_MAX) & ~clr_on_match;
  assign ev[EV_CMA] = match_a;
  assign ev[EV_CMB] = match_b;

  // software write beats counting; the external clear beats a tick
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_reg <= CNT_RST;
    end else if (wr_cnt) begin
      cnt_reg <= PWDATA[7:0];
    end else if (ext_clr || (tick && clr_on_match)) begin
      cnt_reg <= CNT_RST;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // per flag: armed by a read that returned 1, consumed by any write
  for (genvar i = 0; i < FLAG_N; i++) begin : g_flag
    always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
        armed_reg[i] <= 1'b0;
      end else if (rd_flags && rdata_reg[FLAG_LSB+i]) begin
        armed_reg[i] <= 1'b1;
      end else if (wr_flags || !flag_reg[i]) begin
        armed_reg[i] <= 1'b0;
      end
    end

    // set wins over clear; writing 1 has no effect
    always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
        flag_reg[i] <= 1'b0;
      end else if (ev[i]) begin
        flag_reg[i] <= 1'b1;
      end else if (wr_flags && !PWDATA[FLAG_LSB+i] && armed_reg[i]) begin
        flag_reg[i] <= 1'b0;
      end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
        irq_sts_reg[i] <= 1'b0;
      end else if (ev[i]) begin
        irq_sts_reg[i] <= 1'b1;
      end else if (wr_irq_clr && PWDATA[i]) begin
        irq_sts_reg[i] <= 1'b0;
      end
    end
  end

  // a compare B action other than OS_NONE wins when both matches land on one tick
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      tmo_reg <= 1'b0;
    end else if (match_b && outsel_reg.os_b != OS_NONE) begin
      tmo_reg <= os_apply(outsel_reg.os_b, tmo_reg);
    end else if (match_a) begin
      tmo_reg <= os_apply(outsel_reg.os_a, tmo_reg);
    end
  end

  assign TMO_OE = |outsel_reg;
  assign TMO = tmo_reg & TMO_OE;

  assign src_en = {ctrl_reg.compare_b_interrupt_enable, ctrl_reg.cmiea, ctrl_reg.ovie};
  assign CMB_REQ = flag_reg[EV_CMB] & ctrl_reg.compare_b_interrupt_enable;
  // status stays sticky even when masked, so a late enable still fires
  assign IRQ = |(irq_sts_reg & irq_en_reg & src_en);

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  chk_ext_edges: assert property (
    ((ctrl_reg.cks == CKS_EXT_RISE && ext_rise) ||
     (ctrl_reg.cks == CKS_EXT_FALL && ext_fall)) |-> tick)
    else $error("selected external edge did not tick the counter");
  chk_cmb_gate: assert property (
    CMB_REQ == (flag_reg[EV_CMB] && ctrl_reg.compare_b_interrupt_enable))
    else $error("compare B request not gated by its enable");
  chk_irq_cmb_mask: assert property (
    (!ctrl_reg.compare_b_interrupt_enable && !irq_sts_reg[EV_OVF] && !irq_sts_reg[EV_CMA]) |-> !IRQ)
    else $error("interrupt raised with compare B masked");
  chk_no_write_set: assert property (
    (wr_flags && PWDATA[FLAG_LSB+EV_OVF] && !flag_reg[EV_OVF] && !ev[EV_OVF])
    |=> !flag_reg[EV_OVF])
    else $error("writing 1 set the overflow flag");
  chk_cma_no_clear: assert property (
    (wr_flags && PWDATA[FLAG_LSB+EV_CMA] && flag_reg[EV_CMA]) |=> flag_reg[EV_CMA])
    else $error("writing 1 cleared the compare A flag");
  chk_cmb_unarmed: assert property (
    (wr_flags && !armed_reg[EV_CMB] && flag_reg[EV_CMB]) |=> flag_reg[EV_CMB])
    else $error("compare B flag cleared without a prior read of 1");
  chk_oe_off: assert property (
    (outsel_reg == OUTSEL_RST) |-> (!TMO_OE && !TMO))
    else $error("output enabled with all select bits zero");
  chk_cmb_set: assert property (
    match_b |=> flag_reg[EV_CMB])
    else $error("compare B match did not set its flag");
  chk_cmb_clear: assert property (
    $fell(flag_reg[EV_CMB]) |-> ($past(armed_reg[EV_CMB]) && $past(wr_flags) &&
                                 !$past(PWDATA[FLAG_LSB+EV_CMB])))
    else $error("compare B flag cleared without read-1 then write-0");
  chk_count_step: assert property (
    (tick && !wr_cnt && !ext_clr && !clr_on_match) |=> cnt_reg == $past(cnt_reg) + 8'h01)
    else $error("counter did not step on a tick");
  chk_ovf_wrap: assert property (
    (tick && cnt_reg == CNT_MAX && !wr_cnt && !ext_clr && !clr_on_match)
    |=> (cnt_reg == CNT_RST && flag_reg[EV_OVF]))
    else $error("wrap did not clear counter and set overflow");

  cov_ext_count: cover property (ctrl_reg.cks == CKS_EXT_FALL && tick);
  cov_cmb_clear: cover property (rd_flags ##[1:8] wr_flags ##1 !flag_reg[EV_CMB]);
  cov_irq: cover property ($rose(IRQ));
  cov_toggle: cover property (match_b && outsel_reg.os_b == OS_TOGGLE);
  cov_ext_clear: cover property (ext_clr);
endmodule

// [t1_pkg.sv]
// package for the 8-bit timer channel one: register indices, field positions,
// reset values, clock-select and output-select codes, carrier structs.
// assumes an APB slave with 32-bit data; byte address = 4 * register index.
package t1_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 8;
  // register indices; byte address is index * 4
  localparam logic [IDX_W-1:0] IDX_CTRL = 8'hD0;
  localparam logic [IDX_W-1:0] IDX_FLAGS = 8'hD1;
  localparam logic [IDX_W-1:0] IDX_CORA = 8'hD2;
  localparam logic [IDX_W-1:0] IDX_CORB = 8'hD3;
  localparam logic [IDX_W-1:0] IDX_CNT = 8'hD4;
  localparam logic [IDX_W-1:0] IDX_IRQ_STS = 8'hD5;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 8'hD6;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN = 8'hD7;
  // flag positions in timer_flags_and_output_select
  localparam int FLAG_LSB = 5;
  localparam int FLAG_N = 3;
  localparam int FIXED_BIT = 4;
  // event index: 0 overflow, 1 compare A, 2 compare B
  localparam int EV_OVF = 0;
  localparam int EV_CMA = 1;
  localparam int EV_CMB = 2;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] COR_RST = 8'hFF;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [3:0] OUTSEL_RST = 4'h0;
  localparam logic [FLAG_N-1:0] FLAG_RST = 3'h0;
  // clock select codes
  localparam logic [2:0] CKS_STOP = 3'h0;
  localparam logic [2:0] CKS_DIV_A = 3'h1;
  localparam logic [2:0] CKS_DIV_B = 3'h2;
  localparam logic [2:0] CKS_DIV_C = 3'h3;
  localparam logic [2:0] CKS_STOP2 = 3'h4;
  localparam logic [2:0] CKS_EXT_RISE = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;
  // counter clear codes
  localparam logic [1:0] CCLR_NONE = 2'h0;
  localparam logic [1:0] CCLR_CMA = 2'h1;
  localparam logic [1:0] CCLR_CMB = 2'h2;
  localparam logic [1:0] CCLR_EXT = 2'h3;
  // output action codes, per compare channel
  localparam logic [1:0] OS_NONE = 2'h0;
  localparam logic [1:0] OS_LOW = 2'h1;
  localparam logic [1:0] OS_HIGH = 2'h2;
  localparam logic [1:0] OS_TOGGLE = 2'h3;

  typedef struct packed {
    logic compare_b_interrupt_enable;
    logic cmiea;
    logic ovie;
    logic [1:0] cclr;
    logic [2:0] cks;
  } t1_ctrl_t;

  typedef struct packed {
    logic [1:0] os_b;
    logic [1:0] os_a;
  } t1_outsel_t;
endpackage

// [t1_ext_pins.sv]
// pin model for the timer's external count clock and counter clear inputs.
// assumes the bench calls its tasks from the MCLK domain.
`timescale 1ns/1ps
module t1_ext_pins (
  input wire logic clk,
  output logic ext_clk,
  output logic ext_rst
);
  initial begin
    ext_clk = 1'b0;
    ext_rst = 1'b0;
  end

  // hold sets how slow the far side is; pins start low and keep the last value driven
  task automatic set_clk(input logic v, input int hold);
    @(posedge clk);
    ext_clk <= v;
    repeat (hold) @(posedge clk);
  endtask

  task automatic set_rst(input logic v, input int hold);
    @(posedge clk);
    ext_rst <= v;
    repeat (hold) @(posedge clk);
  endtask
endmodule

// [t1_timer_tb.sv]
// self-checking bench for t1_timer: APB registers, external pins, flags, irq.
// assumes t1_pkg and the pin model t1_ext_pins are compiled first.
`timescale 1ns/1ps
module t1_timer_tb;
  import t1_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, ext_clk, ext_rst, tmo, tmo_oe, cmb_req, irq;
  logic last_err;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2.5 mclk = ~mclk;

  t1_timer dut_u (.MCLK(mclk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EXT_CLK(ext_clk), .EXT_RST(ext_rst),
    .TMO(tmo), .TMO_OE(tmo_oe), .CMB_REQ(cmb_req), .IRQ(irq));

  t1_ext_pins pins_u (.clk(mclk), .ext_clk(ext_clk), .ext_rst(ext_rst));

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ceiling well above the few hundred cycles the scenarios need
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test;
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one transfer; no wait-state count assumed, only the global ceiling ends a wait
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the edge's register updates settle before any pin is judged
    @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, idx, d, x);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string name);
    logic [31:0] x;
    apb(1'b0, idx, 32'h0, x);
    check(name, x, exp);
  endtask

  task automatic pin(input string name, input logic v, input logic exp);
    check(name, {31'h0, v}, {31'h0, exp});
  endtask

  task automatic test_reset;
    rd(IDX_CTRL, 32'h0, "ctrl reset");
    rd(IDX_FLAGS, 32'h10, "flags reset");
    rd(IDX_CORA, 32'hFF, "cora reset");
    rd(IDX_CORB, 32'hFF, "corb reset");
    rd(IDX_CNT, 32'h0, "count reset");
    rd(IDX_IRQ_STS, 32'h0, "irq sts reset");
    pin("tmo_oe reset", tmo_oe, 1'b0);
    rd(8'h10, 32'h0, "unmapped data");
    pin("unmapped err", last_err, 1'b1);
  endtask

  // rising-edge count into a B match, then enable, output and clearing of the flag
  task automatic test_rise_match_b;
    wr(IDX_CTRL, 32'h85);
    wr(IDX_FLAGS, 32'h08);
    wr(IDX_CORB, 32'h04);
    wr(IDX_CNT, 32'h03);
    pins_u.set_clk(1'b1, 6);
    rd(IDX_CNT, 32'h04, "count rise");
    pins_u.set_clk(1'b0, 6);
    rd(IDX_CNT, 32'h04, "count no fall");
    pins_u.set_clk(1'b1, 6);
    pins_u.set_clk(1'b0, 2);
    rd(IDX_CNT, 32'h05, "count past b");
    rd(IDX_FLAGS, 32'h98, "flag b set");
    pin("cmb_req on", cmb_req, 1'b1);
    pin("tmo high", tmo, 1'b1);
    pin("tmo_oe on", tmo_oe, 1'b1);
    wr(IDX_CTRL, 32'h05);
    pin("cmb_req off", cmb_req, 1'b0);
    wr(IDX_FLAGS, 32'hF0);
    pin("tmo_oe off", tmo_oe, 1'b0);
    pin("tmo off", tmo, 1'b0);
    wr(IDX_FLAGS, 32'h00);
    rd(IDX_FLAGS, 32'h90, "flag b kept");
    wr(IDX_FLAGS, 32'h00);
    rd(IDX_FLAGS, 32'h10, "flag b cleared");
  endtask

  // falling-edge count through the wrap, with the A match at FF and the irq path
  task automatic test_fall_overflow;
    wr(IDX_CTRL, 32'h26);
    wr(IDX_CNT, 32'hFF);
    pins_u.set_clk(1'b1, 6);
    rd(IDX_CNT, 32'hFF, "count no rise");
    pins_u.set_clk(1'b0, 6);
    rd(IDX_CNT, 32'h00, "count wrap");
    rd(IDX_FLAGS, 32'h70, "ovf and a");
    pin("irq masked", irq, 1'b0);
    wr(IDX_IRQ_EN, 32'h1);
    pin("irq on", irq, 1'b1);
    wr(IDX_IRQ_CLR, 32'h1);
    pin("irq cleared", irq, 1'b0);
    rd(IDX_IRQ_STS, 32'h6, "irq sts left");
  endtask

  // external clear, clear on match B with toggle, then the eighth-rate prescaler
  task automatic test_ext_clear;
    logic [31:0] x;
    wr(IDX_CTRL, 32'h1D);
    wr(IDX_CNT, 32'h20);
    pins_u.set_rst(1'b1, 6);
    rd(IDX_CNT, 32'h00, "count ext clear");
    pins_u.set_rst(1'b0, 2);
    wr(IDX_CTRL, 32'h15);
    wr(IDX_FLAGS, 32'hEC);
    pin("tmo before toggle", tmo, 1'b1);
    wr(IDX_CORB, 32'h01);
    pins_u.set_clk(1'b1, 6);
    pins_u.set_clk(1'b0, 2);
    rd(IDX_CNT, 32'h01, "count before b");
    pins_u.set_clk(1'b1, 6);
    rd(IDX_CNT, 32'h00, "count clear on b");
    rd(IDX_FLAGS, 32'hFC, "flag b on clear");
    pin("tmo toggled", tmo, 1'b0);
    pin("cmb_req masked", cmb_req, 1'b0);
    wr(IDX_CTRL, 32'h01);
    wr(IDX_CNT, 32'h00);
    repeat (80) @(posedge mclk);
    wr(IDX_CTRL, 32'h00);
    apb(1'b0, IDX_CNT, 32'h0, x);
    check("div a rate", {31'h0, x >= 32'h9 && x <= 32'hB}, 32'h1);
  endtask

  initial begin
    last_err = 1'b0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    test_reset;
    test_rise_match_b;
    test_fall_overflow;
    test_ext_clear;
    stop_test;
  end
endmodule
